// >>> hw/ddp_cfg.svh
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH
`define DDP_MR_RST 14'h0000
`define DDP_BL_LO 0
`define DDP_BL_HI 1
`define DDP_BL_OTF 2'h1
`define DDP_BL_BC4 2'h2
`define DDP_TDQS_BIT 11
`define DDP_RTT_NOM_B0 2
`define DDP_RTT_NOM_B1 6
`define DDP_RTT_NOM_B2 9
`define DDP_RTT_WR_LO 9
`define DDP_RTT_WR_HI 10
`define DDP_AP_BIT 10
`define DDP_BC_BIT 12
`define DDP_COL_X4_BIT 11
`define DDP_COL_LO_W 10
`define DDP_ROW_W_X16 13
`define DDP_PAIRS_BL8 3'h4
`define DDP_PAIRS_BC4 3'h2
`define DDP_MR1_IDX 2'h1
`define DDP_MR2_IDX 2'h2
`define DDP_MR0_IDX 2'h0
`endif

// >>> hw/ddp_pkg.sv
package ddp_pkg;
    typedef enum logic [3:0] {
        DDP_DES, DDP_NOP, DDP_MRS, DDP_REF, DDP_PRE,
        DDP_ACT, DDP_WR, DDP_RD, DDP_ZQ
    } ddp_cmd_t;
    typedef enum logic [1:0] {DDP_X4, DDP_X8, DDP_X16} ddp_org_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] bank;
        logic [13:0] row;
        logic [10:0] col;
        logic auto_pre;
        logic chop;
    } ddp_req_t;
    typedef struct packed {
        logic valid;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [3:0] keep;
    } ddp_wbeat_t;
    typedef struct packed {
        logic [15:0] dq;
        logic [1:0] dqs;
        logic [1:0] dm;
        logic tdqs;
    } ddp_term_t;
endpackage

// >>> hw/ddp_pins.sv
`timescale 1ns/1ps
`include "ddp_cfg.svh"
module ddp_pins #(
    parameter ddp_pkg::ddp_org_t ORG = ddp_pkg::DDP_X8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // command and address
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [2:0] ba_i,
    input wire logic [13:0] addr_i,
    input wire logic odt_i,
    // write data side, two beats per clock
    input wire logic [15:0] dq_rise_i,
    input wire logic [15:0] dq_fall_i,
    input wire logic [1:0] dm_rise_i,
    input wire logic [1:0] dm_fall_i,
    input wire logic [1:0] dqs_t_i,
    input wire logic [1:0] dqs_c_i,
    // read data side
    output logic [15:0] dq_rise_o,
    output logic [15:0] dq_fall_o,
    output logic dq_oe_o,
    output logic [1:0] dqs_t_o,
    output logic [1:0] dqs_c_o,
    output logic [1:0] dqs_oe_o,
    // array side
    input wire logic [31:0] rd_data_i,
    output ddp_pkg::ddp_req_t req_o,
    output ddp_pkg::ddp_wbeat_t wr_o,
    output ddp_pkg::ddp_term_t term_o,
    output logic [11:0] page_bytes_o
);
    localparam int COL_W = `DDP_COL_LO_W + ((ORG == ddp_pkg::DDP_X4) ? 1 : 0);
    localparam int DQ_W = (ORG == ddp_pkg::DDP_X4) ? 4 : (ORG == ddp_pkg::DDP_X8) ? 8 : 16;
    localparam int PAGE = (1 << `DDP_COL_LO_W) * ((ORG == ddp_pkg::DDP_X16) ? 16 : 8) / 8;
    localparam logic [15:0] DQ_MASK = 16'((32'h1 << DQ_W) - 1);
    localparam logic [1:0] LANES = (ORG == ddp_pkg::DDP_X16) ? 2'h3 : 2'h1;
    localparam logic [13:0] ROW_MASK = (ORG == ddp_pkg::DDP_X16) ?
        14'((32'h1 << `DDP_ROW_W_X16) - 1) : 14'h3fff;

    function automatic ddp_pkg::ddp_cmd_t cmd_decode(input logic [3:0] c);
        ddp_pkg::ddp_cmd_t r;
        r = ddp_pkg::DDP_DES;
        case (c)
            4'h0: r = ddp_pkg::DDP_MRS;
            4'h1: r = ddp_pkg::DDP_REF;
            4'h2: r = ddp_pkg::DDP_PRE;
            4'h3: r = ddp_pkg::DDP_ACT;
            4'h4: r = ddp_pkg::DDP_WR;
            4'h5: r = ddp_pkg::DDP_RD;
            4'h6: r = ddp_pkg::DDP_ZQ;
            4'h7: r = ddp_pkg::DDP_NOP;
            default: r = ddp_pkg::DDP_DES;
        endcase
        return r;
    endfunction

    // command pins registered on the rising edge
    logic cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q;
    logic [2:0] ba_q;
    logic [13:0] addr_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cke_q <= 1'b0;
            cs_n_q <= 1'b1;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            we_n_q <= 1'b1;
            odt_q <= 1'b0;
            ba_q <= 3'h0;
            addr_q <= 14'h0000;
        end else begin
            cke_q <= cke_i;
            cs_n_q <= cs_n_i;
            ras_n_q <= ras_n_i;
            cas_n_q <= cas_n_i;
            we_n_q <= we_n_i;
            odt_q <= odt_i;
            ba_q <= ba_i;
            addr_q <= addr_i;
        end
    end

    // with clock enable low every command decodes as deselect; bursts, write beats and termination still run
    wire ddp_pkg::ddp_cmd_t cmd = cke_q ?
        cmd_decode({cs_n_q, ras_n_q, cas_n_q, we_n_q}) : ddp_pkg::DDP_DES;
    wire is_rd = (cmd == ddp_pkg::DDP_RD);
    wire is_wr = (cmd == ddp_pkg::DDP_WR);
    wire is_act = (cmd == ddp_pkg::DDP_ACT);
    wire is_mrs = (cmd == ddp_pkg::DDP_MRS) && !ba_q[2];

    // mode registers
    logic [13:0] mr_q [4];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                mr_q[i] <= `DDP_MR_RST;
            end
        end else if (is_mrs) begin
            mr_q[ba_q[1:0]] <= addr_q;
        end
    end
    wire [13:0] mr0 = mr_q[`DDP_MR0_IDX];
    wire [13:0] mr1 = mr_q[`DDP_MR1_IDX];
    wire [13:0] mr2 = mr_q[`DDP_MR2_IDX];
    wire [1:0] bl_mode = mr0[`DDP_BL_HI:`DDP_BL_LO];
    wire tdqs_on = (ORG == ddp_pkg::DDP_X8) && mr1[`DDP_TDQS_BIT];
    wire mask_en = !tdqs_on;
    wire rtt_nom = mr1[`DDP_RTT_NOM_B0] | mr1[`DDP_RTT_NOM_B1] | mr1[`DDP_RTT_NOM_B2];
    wire rtt_wr = |mr2[`DDP_RTT_WR_HI:`DDP_RTT_WR_LO];
    wire rtt_any = rtt_nom | rtt_wr;

    // burst length: fixed, chopped, or picked per access by address 12
    wire chop = (bl_mode == `DDP_BL_BC4) ||
        ((bl_mode == `DDP_BL_OTF) && !addr_q[`DDP_BC_BIT]);
    wire [2:0] pairs = chop ? `DDP_PAIRS_BC4 : `DDP_PAIRS_BL8;

    // open row per bank
    logic [13:0] row_q [8];
    wire [13:0] row_in = addr_q & ROW_MASK;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int b = 0; b < 8; b++) begin
                row_q[b] <= 14'h0000;
            end
        end else if (is_act) begin
            row_q[ba_q] <= row_in;
        end
    end

    // column: x4 carries one extra bit taken from address 11
    wire [10:0] col_in = (COL_W > `DDP_COL_LO_W) ?
        {addr_q[`DDP_COL_X4_BIT], addr_q[9:0]} : {1'b0, addr_q[9:0]};

    ddp_pkg::ddp_req_t req_d;
    always_comb begin
        req_d.valid = is_rd | is_wr;
        req_d.write = is_wr;
        req_d.bank = ba_q;
        req_d.row = row_q[ba_q];
        req_d.col = col_in;
        req_d.auto_pre = addr_q[`DDP_AP_BIT];
        req_d.chop = chop;
    end

    // burst counters in beat pairs; a new command restarts the burst
    logic [2:0] rd_left_q, wr_left_q;
    wire rd_busy = (rd_left_q != 3'h0);
    wire wr_busy = (wr_left_q != 3'h0);

    // a strobe pair counts only when true and complement differ
    wire [1:0] dqs_ok = (dqs_t_i ^ dqs_c_i) & LANES;
    wire beat_ok = dqs_ok[0];
    wire [1:0] dm_r = dm_rise_i & {2{mask_en}};
    wire [1:0] dm_f = dm_fall_i & {2{mask_en}};
    // each lane is kept by its own strobe and mask per half cycle
    logic [3:0] keep_d;
    for (genvar ln = 0; ln < 2; ln++) begin : g_lane
        // low pair of keep is the rising half, high pair the falling half
        assign keep_d[ln] = dqs_ok[ln] & ~dm_r[ln];
        assign keep_d[ln + 2] = dqs_ok[ln] & ~dm_f[ln];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_left_q <= 3'h0;
        end else if (is_rd) begin
            rd_left_q <= pairs;
        end else if (rd_busy) begin
            rd_left_q <= rd_left_q - 3'h1;
        end
    end

    // write beats only advance on a valid strobe, so gaps just wait
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_left_q <= 3'h0;
        end else if (is_wr) begin
            wr_left_q <= pairs;
        end else if (wr_busy && beat_ok) begin
            wr_left_q <= wr_left_q - 3'h1;
        end
    end

    ddp_pkg::ddp_wbeat_t wr_d;
    always_comb begin
        wr_d.valid = wr_busy && beat_ok;
        wr_d.rise = dq_rise_i & DQ_MASK;
        wr_d.fall = dq_fall_i & DQ_MASK;
        wr_d.keep = keep_d;
    end

    // only data-side pins are terminated; command pins have none
    ddp_pkg::ddp_term_t term_d;
    wire term_on = odt_q && rtt_any;
    always_comb begin
        term_d.dq = {16{term_on}} & DQ_MASK;
        term_d.dqs = {2{term_on}} & LANES;
        term_d.dm = {2{term_on}} & LANES;
        term_d.tdqs = term_on && tdqs_on;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_o <= '0;
            wr_o <= '0;
            term_o <= '0;
            page_bytes_o <= 12'(PAGE);
        end else begin
            req_o <= req_d;
            wr_o <= wr_d;
            term_o <= term_d;
            page_bytes_o <= 12'(PAGE);
        end
    end

    // read strobe is held true high, complement low, on the lanes in use while data is driven
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_oe_o <= 1'b0;
            dq_rise_o <= 16'h0000;
            dq_fall_o <= 16'h0000;
            dqs_t_o <= 2'h0;
            dqs_c_o <= 2'h0;
            dqs_oe_o <= 2'h0;
        end else begin
            dq_oe_o <= rd_busy;
            dq_rise_o <= rd_busy ? (rd_data_i[15:0] & DQ_MASK) : 16'h0000;
            dq_fall_o <= rd_busy ? (rd_data_i[31:16] & DQ_MASK) : 16'h0000;
            dqs_t_o <= rd_busy ? LANES : 2'h0;
            dqs_c_o <= 2'h0;
            dqs_oe_o <= rd_busy ? LANES : 2'h0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_chop_rd;
        is_rd && chop;
    endsequence
    sequence s_quiet2;
        (!is_rd)[*2];
    endsequence
    sequence s_full_rd;
        is_rd && !chop;
    endsequence
    sequence s_quiet6;
        (!is_rd)[*6];
    endsequence
    sequence s_access;
        is_rd || is_wr;
    endsequence

    a_cs_masks: assert property (cs_n_q |=> !req_o.valid)
        else $error("command taken with chip select high");
    a_mrs_load: assert property (is_mrs |=> mr_q[$past(ba_q[1:0])] == $past(addr_q))
        else $error("mode register not loaded from address");
    a_act_row: assert property (is_act |=> row_q[$past(ba_q)] == ($past(addr_q) & ROW_MASK))
        else $error("row not stored for bank");
    a_chop_len: assert property (s_chop_rd ##1 s_quiet2 |-> dq_oe_o ##1 dq_oe_o ##1 !dq_oe_o)
        else $error("chopped read not two beat pairs");
    a_mask_drop: assert property (wr_busy && beat_ok && mask_en && dm_rise_i[0]
        |=> wr_o.valid && !wr_o.keep[0])
        else $error("masked beat was kept");
    a_tdqs_off: assert property (wr_busy && beat_ok && tdqs_on |=> wr_o.keep[0] && wr_o.keep[2])
        else $error("mask applied while pin is termination strobe");
    a_single_end: assert property (wr_busy && (dqs_t_i[0] == dqs_c_i[0]) |=> !wr_o.valid)
        else $error("beat taken without differential strobe");
    a_term_gate: assert property (!rtt_any |=> term_o == '0)
        else $error("termination on although disabled");
    a_rd_strobe: assert property (dq_oe_o |-> dqs_oe_o[0] && (dqs_t_o[0] != dqs_c_o[0]))
        else $error("read data without aligned strobe");
    a_rd_lanes: assert property (dq_oe_o |-> (dqs_t_o == LANES) && (dqs_oe_o == LANES))
        else $error("read strobe lanes do not match width");

    // judged once the burst has drained, so a later read cannot stretch it
    a_full_len: assert property (s_full_rd ##1 s_quiet6 |-> !dq_oe_o && $past(dq_oe_o, 1)
        && $past(dq_oe_o, 2) && $past(dq_oe_o, 3) && $past(dq_oe_o, 4))
        else $error("full read not four beat pairs");

    a_wr_load: assert property (is_wr
        |=> wr_left_q == ($past(chop) ? `DDP_PAIRS_BC4 : `DDP_PAIRS_BL8))
        else $error("write burst length not loaded");
    a_wr_hold: assert property (wr_busy && !beat_ok && !is_wr
        |=> $stable(wr_left_q) && !wr_o.valid)
        else $error("write beat taken without strobe");

    a_req_kind: assert property (s_access
        |=> req_o.valid && (req_o.write == $past(is_wr)))
        else $error("request kind does not match command");
    a_req_idle: assert property (!is_rd && !is_wr |=> !req_o.valid)
        else $error("request without read or write");
    a_acc_fields: assert property (s_access |=> req_o.bank == $past(ba_q)
        && req_o.auto_pre == $past(addr_q[`DDP_AP_BIT])
        && req_o.col[`DDP_COL_LO_W-1:0] == $past(addr_q[`DDP_COL_LO_W-1:0]))
        else $error("access fields not taken from pins");
    a_cs_cmd: assert property (cs_n_q |-> !is_rd && !is_wr && !is_mrs && !is_act)
        else $error("command decoded with chip select high");

    a_term_on: assert property (odt_q && rtt_any
        |=> term_o.dq[0] && term_o.dqs[0] && term_o.dm[0])
        else $error("termination missing while requested");
    a_term_off: assert property (!odt_q |=> term_o == '0)
        else $error("termination on without request");
    a_tdqs_term: assert property (term_o.tdqs |-> $past(tdqs_on))
        else $error("strobe termination while pin is a mask");

    // no read data or write beat leaves the block between bursts
    a_rd_idle: assert property (!rd_busy |=> !dq_oe_o && (dqs_oe_o == 2'h0))
        else $error("read pins driven outside a burst");
    a_wr_idle: assert property (!wr_busy |=> !wr_o.valid)
        else $error("write beat passed outside a burst");
endmodule

// >>> sim/ddp_ctl_model.sv
`timescale 1ns/1ps
module ddp_ctl_model (
    // clock
    input wire logic clk_i,
    // command pins
    output logic cke_o,
    output logic cs_n_o,
    output logic [2:0] rcw_n_o,
    output logic [2:0] ba_o,
    output logic [13:0] addr_o,
    output logic odt_o,
    // write data pins
    output logic [15:0] dq_r_o,
    output logic [15:0] dq_f_o,
    output logic [1:0] dm_r_o,
    output logic [1:0] dm_f_o,
    output logic [1:0] dqs_t_o,
    output logic [1:0] dqs_c_o
);
    initial begin
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        rcw_n_o = 3'h7;
        ba_o = 3'h0;
        addr_o = 14'h0;
        odt_o = 1'b0;
        dq_r_o = 16'h0;
        dq_f_o = 16'h0;
        dm_r_o = 2'h0;
        dm_f_o = 2'h0;
        dqs_t_o = 2'h0;
        dqs_c_o = 2'h0;
    end
    // one command cycle, then deselect with the bus inverted so stale values never match
    task automatic cmd(input logic [2:0] rcw, input logic cs_n, input logic [2:0] ba,
                       input logic [13:0] a);
        @(negedge clk_i);
        cs_n_o <= cs_n;
        rcw_n_o <= rcw;
        ba_o <= ba;
        addr_o <= a;
        @(negedge clk_i);
        cs_n_o <= 1'b1;
        rcw_n_o <= ~rcw;
        ba_o <= ~ba;
        addr_o <= ~a;
    endtask
    // one beat pair; a lane with ok low shows true equal to complement
    task automatic beat(input logic [31:0] d, input logic [3:0] m, input logic [1:0] ok);
        @(negedge clk_i);
        {dq_f_o, dq_r_o} <= d;
        {dm_f_o, dm_r_o} <= m;
        dqs_t_o <= 2'h3;
        dqs_c_o <= ~ok;
        @(negedge clk_i);
        {dq_f_o, dq_r_o} <= ~d;
        {dm_f_o, dm_r_o} <= ~m;
        dqs_t_o <= 2'h0;
        dqs_c_o <= 2'h0;
    endtask
    // termination request, changed between clock edges only
    task automatic term_req(input logic on);
        @(negedge clk_i);
        odt_o <= on;
    endtask
endmodule

// >>> sim/test_ddp_pins.sv
`timescale 1ns/1ps
module test_ddp_pins;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cke, cs_n, odt, rd_oe;
    logic [2:0] rcw_n, ba;
    logic [13:0] addr;
    logic [15:0] dq_r, dq_f, rd_r, rd_f;
    logic [1:0] dm_r, dm_f, dqs_t, dqs_c, rs_t, rs_c, rs_oe;
    logic [31:0] rd_data = 32'h5a5a_c3c3;
    logic [11:0] page;
    ddp_pkg::ddp_req_t req;
    ddp_pkg::ddp_wbeat_t wr;
    ddp_pkg::ddp_term_t term;
    int err_count = 0;
    int n_compared = 0;
    always #2 clk_i = ~clk_i;
    ddp_ctl_model ctl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .rcw_n_o(rcw_n), .ba_o(ba),
        .addr_o(addr), .odt_o(odt), .dq_r_o(dq_r), .dq_f_o(dq_f), .dm_r_o(dm_r), .dm_f_o(dm_f),
        .dqs_t_o(dqs_t), .dqs_c_o(dqs_c));
    ddp_pins ddp_pins_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cke_i(cke), .cs_n_i(cs_n),
        .ras_n_i(rcw_n[2]), .cas_n_i(rcw_n[1]), .we_n_i(rcw_n[0]), .ba_i(ba), .addr_i(addr),
        .odt_i(odt), .dq_rise_i(dq_r), .dq_fall_i(dq_f), .dm_rise_i(dm_r), .dm_fall_i(dm_f),
        .dqs_t_i(dqs_t), .dqs_c_i(dqs_c), .dq_rise_o(rd_r), .dq_fall_o(rd_f), .dq_oe_o(rd_oe),
        .dqs_t_o(rs_t), .dqs_c_o(rs_c), .dqs_oe_o(rs_oe), .rd_data_i(rd_data), .req_o(req),
        .wr_o(wr), .term_o(term), .page_bytes_o(page));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_reset();
        chk(32'(page), 32'd1024);
        chk(32'(req), 32'h0);
        chk(32'(term), 32'h0);
    endtask
    task automatic t_act_wr();
        logic [3:0] m;
        logic [31:0] g, e;
        ctl.cmd(3'h3, 1'b0, 3'h5, 14'h2abc);
        repeat (2) @(negedge clk_i);
        ctl.cmd(3'h4, 1'b0, 3'h5, 14'h0da5);
        @(negedge clk_i);
        chk(req, {2'b11, 3'h5, 14'h2abc, 11'h1a5, 2'b10});
        ctl.beat(32'h1111_2222, 4'h0, 2'h0);
        chk(32'(wr.valid), 32'h0);
        for (int i = 0; i < 5; i++) begin
            m = 4'(i * 5) & 4'h5;
            ctl.beat({16'(8'h30 + i), 16'(8'h40 + i)}, m, 2'h1);
            g = 32'({wr.valid, wr.keep[2], wr.keep[0], wr.fall[7:0], wr.rise[7:0]});
            e = 32'({1'b1, ~m[2], ~m[0], 8'(8'h30 + i), 8'(8'h40 + i)});
            if (i < 4) chk(g, e);
            else chk(32'(wr.valid), 32'h0);
        end
    endtask
    task automatic t_cs();
        ctl.cmd(3'h5, 1'b1, 3'h5, 14'h0000);
        repeat (4) begin
            @(negedge clk_i);
            chk(32'({req.valid, rd_oe}), 32'h0);
        end
    endtask
    task automatic t_otf();
        int n;
        ctl.cmd(3'h0, 1'b0, 3'h0, 14'h0001);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            ctl.cmd(3'h5, 1'b0, 3'h5, 14'(k) << 12);
            @(negedge clk_i);
            chk(32'({req.valid, req.write, req.chop}), 32'({2'b10, ~k[0]}));
            repeat (6) begin
                @(negedge clk_i);
                if (rd_oe === 1'b1) begin
                    n++;
                    chk(32'({rs_t[0], rs_c[0], rd_f[7:0], rd_r[7:0]}), 32'h2_5ac3);
                    chk(32'(rs_oe), 32'h1);
                end
            end
            chk(32'(n), (k == 1) ? 32'd4 : 32'd2);
        end
    endtask
    task automatic t_odt();
        ctl.term_req(1'b1);
        ctl.cmd(3'h0, 1'b0, 3'h1, 14'h0804);
        repeat (3) @(negedge clk_i);
        chk(32'({term.dqs[0], term.tdqs, term.dq[0]}), 32'h7);
        ctl.cmd(3'h4, 1'b0, 3'h5, 14'h0000);
        repeat (2) begin
            ctl.beat(32'h0, 4'hf, 2'h1);
            chk(32'({wr.valid, wr.keep[2], wr.keep[0]}), 32'h7);
        end
        ctl.cmd(3'h0, 1'b0, 3'h1, 14'h0000);
        repeat (3) @(negedge clk_i);
        chk(32'(term), 32'h0);
        ctl.cmd(3'h0, 1'b0, 3'h2, 14'h0200);
        repeat (3) @(negedge clk_i);
        chk(32'({term.dqs[0], term.tdqs, term.dq[0]}), 32'h5);
        ctl.term_req(1'b0);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset();
        $display("test reset done");
        t_act_wr();
        $display("test activate and write done");
        t_cs();
        $display("test deselect done");
        t_otf();
        $display("test burst switch done");
        t_odt();
        $display("test termination done");
        conclude();
    end
endmodule
